// >>> ssr_pkg.sv
// Constants, register map and bit layout of the special status relay words
// Function
// - Scan toggle bit inverts at the end of every program scan.
// - First-scan high pulse is one only during the first run scan.
// - First-scan low pulse is zero only during the first run scan.
// - Step-start pulse is one only for a started process's first scan.
// - Free-running square bits with 10 ms, 20 ms and 100 ms periods.
// - Free-running square bits with 200 ms, 1 s and 2 s periods.
// - Free-running square bit with a one minute period.
// - Run indication follows the mode selector: run is one, program zero.
// - Message-active bit is one while the message instruction executes.
// - Forcing-active bit is one while any contact is being forced.
// - Interrupt-enabled bit is one while the external trigger is enabled.
// - Interrupt fault bit is set when an interrupt error occurs.
// - Sample-point bit: zero for instruction sampling, one for timed sampling.
// - Trace-finished bit sets when sampling stops, clears when it starts.
// - Stop-trigger bit follows the sampling stop trigger.
// - Sampling-enabled bit sets when sampling starts, clears when it stops.
// - The four trace bits exist only in the large memory configuration.
package ssr_pkg;

    // Register byte offsets
    localparam logic [3:0] OFS_PULSE_WORD = 4'h0;
    localparam logic [3:0] OFS_MODE_WORD  = 4'h4;
    localparam logic [3:0] OFS_CONTROL    = 4'h8;
    localparam logic [3:0] OFS_COMMAND    = 4'hC;

    // Pulse word bit positions
    localparam int BIT_CONST_ONE   = 0;
    localparam int BIT_CONST_ZERO  = 1;
    localparam int BIT_SCAN_TOGGLE = 2;
    localparam int BIT_FIRST_HIGH  = 3;
    localparam int BIT_FIRST_LOW   = 4;
    localparam int BIT_STEP_START  = 5;
    localparam int BIT_PULSE_BASE  = 8;
    localparam int NUM_PULSES      = 7;

    // Mode flag word bit positions
    localparam int BIT_RUN         = 0;
    localparam int BIT_MSG_ACTIVE  = 6;
    localparam int BIT_FORCING     = 9;
    localparam int BIT_INT_ENABLED = 10;
    localparam int BIT_INT_FAULT   = 11;
    localparam int BIT_SAMPLE_PT   = 12;
    localparam int BIT_TRACE_DONE  = 13;
    localparam int BIT_STOP_TRIG   = 14;
    localparam int BIT_SAMPLING_EN = 15;

    // Implemented bits, everything else reads zero
    localparam logic [15:0] PULSE_WORD_MASK = 16'h7F3D;
    localparam logic [15:0] MODE_WORD_MASK  = 16'hFE41;
    localparam logic [15:0] TRACE_BITS_MASK = 16'hF000;

    // Control register fields and reset value
    localparam int          CTRL_PULSE_RUN  = 0;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
    localparam int          CMD_FAULT_CLEAR = 0;

    // Timebase: one tick per 5 ms half period of the fastest pulse
    localparam int unsigned CLK_FREQ_HZ     = 10_000_000;
    localparam int unsigned BASE_HALF_US    = 5000;
    localparam int unsigned BASE_TICK_CYCLES = (CLK_FREQ_HZ / 1_000_000) * BASE_HALF_US;

    // Half periods in base ticks: 5 ms, 10 ms, 50 ms, 100 ms, 500 ms, 1 s, 30 s
    localparam int          PCNT_W = 13;
    localparam logic [PCNT_W-1:0] PULSE_HALF_TICKS [0:NUM_PULSES-1] = '{
        13'h0001, 13'h0002, 13'h000A, 13'h0014, 13'h0064, 13'h00C8, 13'h1770
    };

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : ssr_pkg

// >>> ssr_status_words.sv
// Special status relay words with an AXI4-Lite register slave
`timescale 1ns/1ps
module ssr_status_words #(
    parameter int unsigned TICK_CYCLES = ssr_pkg::BASE_TICK_CYCLES,
    parameter bit          LARGE_MEM   = 1'b1
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    input  wire logic        i_scan_done,
    input  wire logic        i_run_mode,
    input  wire logic        i_step_start,
    input  wire logic        i_msg_exec,
    input  wire logic        i_forcing,
    input  wire logic        i_int_enabled,
    input  wire logic        i_int_error,
    input  wire logic        i_trace_timed,
    input  wire logic        i_trace_start,
    input  wire logic        i_trace_stop,
    input  wire logic        i_stop_trig,
    input  wire logic [3:0]  i_s_axi_awaddr,
    input  wire logic        i_s_axi_awvalid,
    output logic             o_s_axi_awready,
    input  wire logic [31:0] i_s_axi_wdata,
    input  wire logic [3:0]  i_s_axi_wstrb,
    input  wire logic        i_s_axi_wvalid,
    output logic             o_s_axi_wready,
    output logic [1:0]       o_s_axi_bresp,
    output logic             o_s_axi_bvalid,
    input  wire logic        i_s_axi_bready,
    input  wire logic [3:0]  i_s_axi_araddr,
    input  wire logic        i_s_axi_arvalid,
    output logic             o_s_axi_arready,
    output logic [31:0]      o_s_axi_rdata,
    output logic [1:0]       o_s_axi_rresp,
    output logic             o_s_axi_rvalid,
    input  wire logic        i_s_axi_rready,
    output logic [15:0]      o_pulse_word,
    output logic [15:0]      o_mode_word
);

    localparam int TCNT_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam int NP     = ssr_pkg::NUM_PULSES;

    // Scan and flag state
    logic              run_prev_reg;
    logic              scan_toggle_reg;
    logic              first_pending_reg;
    logic              step_pending_reg;
    logic              run_ind_reg;
    logic              msg_reg;
    logic              forcing_reg;
    logic              int_en_reg;
    logic              fault_reg;
    logic              sample_pt_reg;
    logic              trace_done_reg;
    logic              stop_trig_reg;
    logic              sampling_reg;
    logic [31:0]       ctrl_reg;
    logic [TCNT_W-1:0] tick_cnt_reg;
    wire logic [NP-1:0] pulse_reg;

    // Bus state
    logic              aw_hold_reg;
    logic [3:0]        awaddr_reg;
    logic              w_hold_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;

    wire logic pulse_run   = ctrl_reg[ssr_pkg::CTRL_PULSE_RUN];
    wire logic tick        = pulse_run && (tick_cnt_reg == TCNT_W'(TICK_CYCLES - 1));
    wire logic run_entry   = i_run_mode && !run_prev_reg;
    wire logic trace_impl  = LARGE_MEM;

    wire logic aw_fire     = i_s_axi_awvalid && o_s_axi_awready;
    wire logic w_fire      = i_s_axi_wvalid && o_s_axi_wready;
    wire logic wr_do       = i_ce && aw_hold_reg && w_hold_reg && !bvalid_reg;
    wire logic ar_fire     = i_s_axi_arvalid && o_s_axi_arready;
    wire logic wr_ctrl     = wr_do && (awaddr_reg == ssr_pkg::OFS_CONTROL);
    wire logic wr_cmd      = wr_do && (awaddr_reg == ssr_pkg::OFS_COMMAND);
    wire logic wr_ro       = wr_do && ((awaddr_reg == ssr_pkg::OFS_PULSE_WORD)
                                    || (awaddr_reg == ssr_pkg::OFS_MODE_WORD));
    wire logic fault_clear = wr_cmd && wstrb_reg[0] && wdata_reg[ssr_pkg::CMD_FAULT_CLEAR];

    // Status word assembly
    logic [15:0] pulse_word;
    logic [15:0] mode_word;
    always_comb begin
        pulse_word = 16'h0000;
        pulse_word[ssr_pkg::BIT_CONST_ONE]  = 1'b1;
        pulse_word[ssr_pkg::BIT_CONST_ZERO] = 1'b0;
        pulse_word[ssr_pkg::BIT_SCAN_TOGGLE] = scan_toggle_reg;
        pulse_word[ssr_pkg::BIT_FIRST_HIGH] = first_pending_reg;
        pulse_word[ssr_pkg::BIT_FIRST_LOW]  = !first_pending_reg;
        pulse_word[ssr_pkg::BIT_STEP_START] = step_pending_reg;
        pulse_word[ssr_pkg::BIT_PULSE_BASE +: NP] = pulse_reg;
        mode_word = 16'h0000;
        mode_word[ssr_pkg::BIT_RUN]         = run_ind_reg;
        mode_word[ssr_pkg::BIT_MSG_ACTIVE]  = msg_reg;
        mode_word[ssr_pkg::BIT_FORCING]     = forcing_reg;
        mode_word[ssr_pkg::BIT_INT_ENABLED] = int_en_reg;
        mode_word[ssr_pkg::BIT_INT_FAULT]   = fault_reg;
        mode_word[ssr_pkg::BIT_SAMPLE_PT]   = sample_pt_reg;
        mode_word[ssr_pkg::BIT_TRACE_DONE]  = trace_done_reg;
        mode_word[ssr_pkg::BIT_STOP_TRIG]   = stop_trig_reg;
        mode_word[ssr_pkg::BIT_SAMPLING_EN] = sampling_reg;
    end

    assign o_pulse_word = pulse_word & ssr_pkg::PULSE_WORD_MASK;
    assign o_mode_word  = mode_word & ssr_pkg::MODE_WORD_MASK;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scan_toggle_reg <= 1'b0;
        end else if (i_ce && i_scan_done) begin
            scan_toggle_reg <= !scan_toggle_reg;
        end
    end

    // first run scan tracking, entry wins over scan end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            run_prev_reg      <= 1'b0;
            first_pending_reg <= 1'b0;
        end else if (i_ce) begin
            run_prev_reg <= i_run_mode;
            if (run_entry) begin
                first_pending_reg <= 1'b1;
            end else if (i_scan_done || !i_run_mode) begin
                first_pending_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            step_pending_reg <= 1'b0;
        end else if (i_ce) begin
            if (i_step_start) begin
                step_pending_reg <= 1'b1;
            end else if (i_scan_done) begin
                step_pending_reg <= 1'b0;
            end
        end
    end

    // Level flags; registered once so all bits change on the same edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            run_ind_reg   <= 1'b0;
            msg_reg       <= 1'b0;
            forcing_reg   <= 1'b0;
            int_en_reg    <= 1'b0;
            sample_pt_reg <= 1'b0;
            stop_trig_reg <= 1'b0;
        end else if (i_ce) begin
            run_ind_reg   <= i_run_mode;
            msg_reg       <= i_msg_exec;
            forcing_reg   <= i_forcing;
            int_en_reg    <= i_int_enabled;
            sample_pt_reg <= trace_impl && i_trace_timed;
            stop_trig_reg <= trace_impl && i_stop_trig;
        end
    end

    // interrupt fault, error wins over software clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fault_reg <= 1'b0;
        end else if (i_ce) begin
            if (i_int_error) begin
                fault_reg <= 1'b1;
            end else if (fault_clear) begin
                fault_reg <= 1'b0;
            end
        end
    end

    // trace run state, stop wins when both arrive
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trace_done_reg <= 1'b0;
            sampling_reg   <= 1'b0;
        end else if (i_ce && trace_impl) begin
            if (i_trace_stop) begin
                trace_done_reg <= 1'b1;
                sampling_reg   <= 1'b0;
            end else if (i_trace_start) begin
                trace_done_reg <= 1'b0;
                sampling_reg   <= 1'b1;
            end
        end
    end

    // Base timebase tick
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt_reg <= '0;
        end else if (i_ce && pulse_run) begin
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + TCNT_W'(1);
        end
    end

    // square pulses from the shared tick
    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_pulse
            logic [ssr_pkg::PCNT_W-1:0] cnt_reg;
            logic                       level_reg;
            wire logic wrap = (cnt_reg == ssr_pkg::PULSE_HALF_TICKS[g] - 13'h0001);
            // One driver per bit, gathered into the word
            assign pulse_reg[g] = level_reg;
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    cnt_reg   <= '0;
                    level_reg <= 1'b0;
                end else if (i_ce && tick) begin
                    cnt_reg <= wrap ? '0 : cnt_reg + 13'h0001;
                    if (wrap) begin
                        level_reg <= !level_reg;
                    end
                end
            end
        end
    endgenerate

    // AXI4-Lite write channel; address and data taken in either order
    assign o_s_axi_awready = i_ce && !aw_hold_reg && !bvalid_reg;
    assign o_s_axi_wready  = i_ce && !w_hold_reg && !bvalid_reg;
    assign o_s_axi_bvalid  = bvalid_reg;
    assign o_s_axi_bresp   = bresp_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_hold_reg <= 1'b0;
            awaddr_reg  <= 4'h0;
            w_hold_reg  <= 1'b0;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
        end else if (i_ce) begin
            if (aw_fire) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= {i_s_axi_awaddr[3:2], 2'b00};
            end else if (wr_do) begin
                aw_hold_reg <= 1'b0;
            end
            if (w_fire) begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= i_s_axi_wdata;
                wstrb_reg  <= i_s_axi_wstrb;
            end else if (wr_do) begin
                w_hold_reg <= 1'b0;
            end
        end
    end

    // Writes to the status words are ignored but answered OKAY
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= ssr_pkg::RESP_OKAY;
            ctrl_reg   <= ssr_pkg::CTRL_RESET;
        end else if (i_ce) begin
            if (wr_do) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= (wr_ctrl || wr_cmd || wr_ro) ? ssr_pkg::RESP_OKAY
                                                           : ssr_pkg::RESP_SLVERR;
            end else if (i_s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (wr_ctrl && wstrb_reg[0]) begin
                ctrl_reg[ssr_pkg::CTRL_PULSE_RUN] <= wdata_reg[ssr_pkg::CTRL_PULSE_RUN];
            end
        end
    end

    // AXI4-Lite read channel
    wire logic [3:0] rd_addr = {i_s_axi_araddr[3:2], 2'b00};
    wire logic       rd_hit  = (rd_addr == ssr_pkg::OFS_PULSE_WORD)
                            || (rd_addr == ssr_pkg::OFS_MODE_WORD)
                            || (rd_addr == ssr_pkg::OFS_CONTROL)
                            || (rd_addr == ssr_pkg::OFS_COMMAND);
    logic [31:0] rd_mux;
    always_comb begin
        case (rd_addr)
            ssr_pkg::OFS_PULSE_WORD: rd_mux = {16'h0000, o_pulse_word};
            ssr_pkg::OFS_MODE_WORD:  rd_mux = {16'h0000, o_mode_word};
            ssr_pkg::OFS_CONTROL:    rd_mux = ctrl_reg;
            default:                 rd_mux = 32'h0000_0000;
        endcase
    end

    assign o_s_axi_arready = i_ce && !rvalid_reg;
    assign o_s_axi_rvalid  = rvalid_reg;
    assign o_s_axi_rdata   = rdata_reg;
    assign o_s_axi_rresp   = rresp_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= ssr_pkg::RESP_OKAY;
        end else if (i_ce) begin
            if (ar_fire) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_mux;
                rresp_reg  <= rd_hit ? ssr_pkg::RESP_OKAY : ssr_pkg::RESP_SLVERR;
            end else if (i_s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    const_bits_a : assert property (o_pulse_word[1:0] == 2'b01)
        else $error("constant bits wrong");
    scan_toggle_a : assert property (i_ce && i_scan_done |=> scan_toggle_reg != $past(scan_toggle_reg))
        else $error("scan toggle did not invert");
    first_high_a : assert property (i_ce && run_entry |=> o_pulse_word[3] && !o_pulse_word[4])
        else $error("first scan pulse missing after run entry");
    first_end_a : assert property (i_ce && i_scan_done && !run_entry |=> !o_pulse_word[3] && o_pulse_word[4])
        else $error("first scan pulse outlived its scan");
    step_start_a : assert property (i_ce && i_step_start |=> o_pulse_word[5])
        else $error("step start pulse missing");
    pulse_hold_a : assert property (!(i_ce && tick) |=> $stable(pulse_reg))
        else $error("pulse changed without a tick");
    pulse_fast_a : assert property (i_ce && tick |=> o_pulse_word[8] != $past(o_pulse_word[8]))
        else $error("10 ms pulse missed its half period");
    run_follow_a : assert property (i_ce |=> o_mode_word[0] == $past(i_run_mode))
        else $error("run indication does not follow selector");
    msg_follow_a : assert property (i_ce |=> o_mode_word[6] == $past(i_msg_exec))
        else $error("message flag stale");
    force_follow_a : assert property (i_ce |=> o_mode_word[9] == $past(i_forcing))
        else $error("forcing flag stale");
    int_en_follow_a : assert property (i_ce |=> o_mode_word[10] == $past(i_int_enabled))
        else $error("interrupt enable flag stale");
    stop_follow_a : assert property (i_ce && trace_impl
        |=> o_mode_word[14] == $past(i_stop_trig))
        else $error("stop trigger flag stale");
    fault_set_a : assert property (i_ce && i_int_error |=> o_mode_word[11])
        else $error("interrupt fault not set");
    trace_stop_a : assert property (i_ce && i_trace_stop && trace_impl |=> o_mode_word[13] && !o_mode_word[15])
        else $error("trace stop not reflected");
    trace_start_a : assert property (i_ce && i_trace_start && !i_trace_stop && trace_impl |=> !o_mode_word[13] && o_mode_word[15])
        else $error("trace start not reflected");
    trace_small_a : assert property (!trace_impl |-> (o_mode_word & ssr_pkg::TRACE_BITS_MASK) == 16'h0000)
        else $error("trace bits present in small configuration");
    unused_zero_a : assert property ((o_pulse_word & ~ssr_pkg::PULSE_WORD_MASK) == 16'h0000 && (o_mode_word & ~ssr_pkg::MODE_WORD_MASK) == 16'h0000)
        else $error("unused bit reads nonzero");

    run_entry_c : cover property (i_ce && run_entry ##[1:20] i_ce && i_scan_done);
    write_c     : cover property (wr_ctrl);
    read_c      : cover property (ar_fire ##1 rvalid_reg);
    fault_c     : cover property (fault_reg ##1 fault_clear);

endmodule : ssr_status_words

// >>> special_status_relay_words_test.sv
// Self-checking bench for the status relay words over the register bus
`timescale 1ns/1ps
module special_status_relay_words_test;
    localparam int TICK  = 4;
    localparam int LIMIT = 70000;
    `define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin errors++; \
        $display("Error at %0t: got %h expected %h", $time, got, exp); end end
    logic        i_clk = 0, i_rst_n = 0, i_ce = 1, i_scan_done = 0, i_run_mode = 0;
    logic        i_step_start = 0, i_msg_exec = 0, i_forcing = 0, i_int_enabled = 0;
    logic        i_int_error = 0, i_trace_timed = 0, i_trace_start = 0, i_trace_stop = 0;
    logic        i_stop_trig = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [1:0]  bresp, rresp, resp;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [15:0] pw, mw, hold, mw_small;
    logic        prev;
    int          errors = 0, checks_done = 0, cycles = 0, n;
    int          half_ms [0:6] = '{5, 10, 50, 100, 500, 1000, 30000};

    ssr_status_words #(.TICK_CYCLES(TICK), .LARGE_MEM(1'b1)) DUT (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_scan_done(i_scan_done),
        .i_run_mode(i_run_mode), .i_step_start(i_step_start), .i_msg_exec(i_msg_exec),
        .i_forcing(i_forcing), .i_int_enabled(i_int_enabled), .i_int_error(i_int_error),
        .i_trace_timed(i_trace_timed), .i_trace_start(i_trace_start),
        .i_trace_stop(i_trace_stop), .i_stop_trig(i_stop_trig),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
        .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
        .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
        .o_pulse_word(pw), .o_mode_word(mw));

    // Small memory build: trace bits must stay zero
    ssr_status_words #(.TICK_CYCLES(TICK), .LARGE_MEM(1'b0)) DUT_SMALL (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_scan_done(i_scan_done),
        .i_run_mode(i_run_mode), .i_step_start(i_step_start), .i_msg_exec(i_msg_exec),
        .i_forcing(i_forcing), .i_int_enabled(i_int_enabled), .i_int_error(i_int_error),
        .i_trace_timed(i_trace_timed), .i_trace_start(i_trace_start),
        .i_trace_stop(i_trace_stop), .i_stop_trig(i_stop_trig),
        .i_s_axi_awaddr(4'h0), .i_s_axi_awvalid(1'b0), .o_s_axi_awready(),
        .i_s_axi_wdata(32'h0000_0000), .i_s_axi_wstrb(4'h0), .i_s_axi_wvalid(1'b0),
        .o_s_axi_wready(), .o_s_axi_bresp(), .o_s_axi_bvalid(),
        .i_s_axi_bready(1'b0), .i_s_axi_araddr(4'h0), .i_s_axi_arvalid(1'b0),
        .o_s_axi_arready(), .o_s_axi_rdata(), .o_s_axi_rresp(),
        .o_s_axi_rvalid(), .i_s_axi_rready(1'b0),
        .o_pulse_word(), .o_mode_word(mw_small));

    initial begin
        forever #50 i_clk = ~i_clk;
    end

    task automatic step(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask : step

    // Address and data offered together, each released when taken
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        aw_done = 0;
        w_done  = 0;
        @(posedge i_clk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge i_clk);
            if (!aw_done && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_done = 1;
            end
            if (!w_done && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_done = 1;
            end
        end
        while (bvalid !== 1'b1) @(posedge i_clk);
        resp = bresp;
        bready <= 1'b0;
        #1;
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge i_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge i_clk);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        #1;
    endtask : axi_read

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // Guard against a hung handshake or a dead pulse
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            $display("Error at %0t: timeout", $time);
            close_out();
        end
    end

    initial begin
        logic [31:0] d;
        step(3);
        `CHK(pw, 16'h0011)
        `CHK(mw, 16'h0000)
        @(posedge i_clk) i_rst_n <= 1'b1;
        step(2);
        // Run entry gives one first scan
        @(posedge i_clk) i_run_mode <= 1'b1;
        step(3);
        `CHK(pw[3:0], 4'b1001)
        `CHK(pw[4], 1'b0)
        `CHK(mw[0], 1'b1)
        hold = pw;
        @(posedge i_clk) i_scan_done <= 1'b1;
        @(posedge i_clk) i_scan_done <= 1'b0;
        step(2);
        `CHK(pw[2], ~hold[2])
        `CHK(pw[4:3], 2'b10)
        @(posedge i_clk) i_scan_done <= 1'b1;
        @(posedge i_clk) i_scan_done <= 1'b0;
        step(2);
        `CHK(pw[4:2], {2'b10, hold[2]})
        `CHK(pw & ~ssr_pkg::PULSE_WORD_MASK, 16'h0000)
        // Step start lasts one scan only
        @(posedge i_clk) i_step_start <= 1'b1;
        @(posedge i_clk) i_step_start <= 1'b0;
        step(2);
        `CHK(pw[5], 1'b1)
        @(posedge i_clk) i_scan_done <= 1'b1;
        @(posedge i_clk) i_scan_done <= 1'b0;
        step(2);
        `CHK(pw[5], 1'b0)
        // Clock enable low freezes every bit
        @(posedge i_clk) i_ce <= 1'b0;
        step(1);
        hold = pw;
        @(posedge i_clk) i_scan_done <= 1'b1;
        @(posedge i_clk) i_scan_done <= 1'b0;
        step(8);
        `CHK(pw, hold)
        @(posedge i_clk) i_ce <= 1'b1;
        // Leave run, then enter again
        @(posedge i_clk) i_run_mode <= 1'b0;
        step(3);
        `CHK(mw[0], 1'b0)
        @(posedge i_clk) i_run_mode <= 1'b1;
        step(3);
        `CHK(pw[4:3], 2'b01)
        // Level flags and trace state
        @(posedge i_clk) begin
            i_msg_exec <= 1'b1; i_forcing <= 1'b1; i_int_enabled <= 1'b1;
            i_trace_timed <= 1'b1; i_stop_trig <= 1'b1; i_trace_start <= 1'b1;
        end
        @(posedge i_clk) i_trace_start <= 1'b0;
        step(2);
        `CHK(mw, 16'hD641)
        `CHK(mw_small, 16'h0641)
        @(posedge i_clk) begin
            i_msg_exec <= 1'b0; i_forcing <= 1'b0; i_int_enabled <= 1'b0;
            i_trace_timed <= 1'b0; i_stop_trig <= 1'b0; i_trace_stop <= 1'b1;
        end
        @(posedge i_clk) i_trace_stop <= 1'b0;
        step(2);
        `CHK(mw, 16'h2001)
        `CHK(mw_small, 16'h0001)
        // Interrupt fault is sticky until the command clears it
        @(posedge i_clk) i_int_error <= 1'b1;
        @(posedge i_clk) i_int_error <= 1'b0;
        step(4);
        `CHK(mw[11], 1'b1)
        axi_write(ssr_pkg::OFS_COMMAND, 32'h0000_0001);
        `CHK(resp, ssr_pkg::RESP_OKAY)
        step(2);
        `CHK(mw[11], 1'b0)
        // Register access; pulses frozen so the word holds still
        axi_read(ssr_pkg::OFS_CONTROL, d);
        `CHK(d, 32'h0000_0001)
        axi_write(ssr_pkg::OFS_CONTROL, 32'h0000_0000);
        step(3);
        hold = pw;
        step(20);
        `CHK(pw, hold)
        axi_read(ssr_pkg::OFS_PULSE_WORD, d);
        `CHK(d, {16'h0000, hold})
        axi_write(ssr_pkg::OFS_PULSE_WORD, 32'hFFFF_FFFF);
        `CHK(resp, ssr_pkg::RESP_OKAY)
        axi_read(ssr_pkg::OFS_MODE_WORD, d);
        `CHK(d, 32'h0000_2001)
        // Low address bits are ignored: 0x6 reads the mode word
        axi_read(4'h6, d);
        `CHK(resp, ssr_pkg::RESP_OKAY)
        `CHK(d, 32'h0000_2001)
        axi_read(ssr_pkg::OFS_COMMAND, d);
        `CHK(d, 32'h0000_0000)
        `CHK(pw, hold)
        axi_write(ssr_pkg::OFS_CONTROL, 32'h0000_0001);
        // Half periods of every free-running pulse, in clock cycles of the scaled timebase
        for (int i = 0; i < 7; i++) begin
            prev = pw[ssr_pkg::BIT_PULSE_BASE + i];
            while (pw[ssr_pkg::BIT_PULSE_BASE + i] === prev) step(1);
            prev = pw[ssr_pkg::BIT_PULSE_BASE + i];
            n = 0;
            while (pw[ssr_pkg::BIT_PULSE_BASE + i] === prev) begin
                step(1);
                n++;
            end
            `CHK(n, half_ms[i] / 5 * TICK)
        end
        close_out();
    end
endmodule : special_status_relay_words_test
